// ### hdl/pcicmd_ctrl.sv
// pci transaction control register and the enables it drives
// assumes config cycles arrive pre-decoded and synchronous to mclk;
// nrst is the bus reset pin, asynchronous and active low
`timescale 1ns/100ps

module pcicmd_ctrl
  import pcicmd_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire pcicmd_cfg_t  cfg_req,
  output logic              cfg_ack,
  output logic [15:0]       cfg_rdata,
  input  wire logic         tgt_valid,
  input  wire pcicmd_kind_t tgt_kind,
  output logic              tgt_claim,
  input  wire logic         mst_want,
  input  wire logic         mst_mwi_ok,
  output logic              mst_req,
  output logic [3:0]        mst_wr_cmd,
  input  wire logic         addr_par_err,
  input  wire logic         data_par_err,
  input  wire logic         data_is_mst_read,
  input  wire logic         data_is_tgt_write,
  input  wire logic         data_is_special,
  output logic              serr_out,
  input  wire logic         detected_parity_error_flag,
  input  wire logic         reported_data_parity_flag,
  input  wire logic         other_irq,
  input  wire logic         irq_enable,
  output logic              perr_out,
  output logic              interrupt_request_line
);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic        cfg_hit;
  logic [15:0] lane_mask;

  // decode is free of any state so access is always possible
  assign cfg_hit   = cfg_req.valid
                     && (cfg_req.offset == PCICMD_OFS_CTRL);
  assign lane_mask = {{8{cfg_req.byte_en[1]}}, {8{cfg_req.byte_en[0]}}};
  // only implemented bits take data; the rest stay zero
  assign ctrl_d    = (cfg_hit && cfg_req.write)
                     ? ((cfg_req.wdata & lane_mask & PCICMD_CTRL_WMASK)
                        | (ctrl_q & ~lane_mask))
                     : ctrl_q;

  logic        mem_en;
  logic        io_en;
  logic        mst_en;
  logic        mwi_en;
  logic        par_en;
  logic        serr_en;
  assign mem_en  = ctrl_q[PCICMD_B_MEM];
  assign io_en   = ctrl_q[PCICMD_B_IO];
  assign mst_en  = ctrl_q[PCICMD_B_MST];
  assign mwi_en  = ctrl_q[PCICMD_B_MWI];
  assign par_en  = ctrl_q[PCICMD_B_PAR];
  assign serr_en = ctrl_q[PCICMD_B_SERR];

  // ----------------------------------------------------------------
  // next values of the outputs
  // ----------------------------------------------------------------
  logic        claim_d;
  logic        mreq_d;
  logic [3:0]  wcmd_d;
  logic        serr_d;
  logic        perr_d;
  logic        irq_d;
  logic [15:0] rdata_d;

  // reads show the masked register, high bits forced to zero
  assign rdata_d = (cfg_hit && !cfg_req.write)
                   ? (ctrl_q & PCICMD_CTRL_WMASK) : 16'h0000;
  assign claim_d = tgt_valid
                   && ((tgt_kind == PCICMD_TK_CFG)
                       || ((tgt_kind == PCICMD_TK_MEM) && mem_en)
                       || ((tgt_kind == PCICMD_TK_ROM) && mem_en)
                       || ((tgt_kind == PCICMD_TK_IO) && io_en));
  assign mreq_d  = mst_want && mst_en;
  assign wcmd_d  = (mwi_en && mst_mwi_ok)
                   ? PCICMD_MEM_WRITE_INV : PCICMD_MEM_WRITE;
  // serr has no master-side term at all
  assign serr_d  = addr_par_err && serr_en && par_en;
  assign perr_d  = data_par_err && par_en && !data_is_special
                   && (data_is_tgt_write || data_is_mst_read);
  assign irq_d   = irq_enable
                   && (other_irq
                       || (par_en
                           && (detected_parity_error_flag
                               || reported_data_parity_flag)));

  // ----------------------------------------------------------------
  // registers: everything clears on bus reset except mst_wr_cmd, which loads the plain write code
  // ----------------------------------------------------------------

  // control register; reset leaves every enable off
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= PCICMD_CTRL_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // acknowledge one cycle after any hit, whatever the state
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_ack <= 1'b0;
    end
    else
    begin
      cfg_ack <= cfg_hit;
    end
  end

  // read data stands one cycle, zero otherwise to ease muxing
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_rdata <= '0;
    end
    else
    begin
      cfg_rdata <= rdata_d;
    end
  end

  // target claim; decode uses the value before a same-cycle write
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tgt_claim <= 1'b0;
    end
    else
    begin
      tgt_claim <= claim_d;
    end
  end

  // bus request, gated by the master enable
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mst_req <= 1'b0;
    end
    else
    begin
      mst_req <= mreq_d;
    end
  end

  // write command; plain write is the safe choice out of reset
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mst_wr_cmd <= PCICMD_MEM_WRITE;
    end
    else
    begin
      mst_wr_cmd <= wcmd_d;
    end
  end

  // system error request; the pin driver sits outside
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      serr_out <= 1'b0;
    end
    else
    begin
      serr_out <= serr_d;
    end
  end

  // data parity error request
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      perr_out <= 1'b0;
    end
    else
    begin
      perr_out <= perr_d;
    end
  end

  // interrupt line, registered so it cannot glitch
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      interrupt_request_line <= 1'b0;
    end
    else
    begin
      interrupt_request_line <= irq_d;
    end
  end

endmodule // pcicmd_ctrl

// ### hdl/pcicmd_pkg.sv
// package for the pci transaction control register block
// assumes a single clock domain and configuration cycles decoded upstream
package pcicmd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  PCICMD_OFS_CTRL   = 8'h04;
  localparam logic [15:0] PCICMD_CTRL_RESET = 16'h0000;
  // writable bits: 8, 6, 4, 2, 1, 0; all others read zero
  localparam logic [15:0] PCICMD_CTRL_WMASK = 16'h0157;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PCICMD_B_IO   = 0;
  localparam int PCICMD_B_MEM  = 1;
  localparam int PCICMD_B_MST  = 2;
  localparam int PCICMD_B_MWI  = 4;
  localparam int PCICMD_B_PAR  = 6;
  localparam int PCICMD_B_SERR = 8;

  // ----------------------------------------------------------------
  // pci command codes for master writes
  // ----------------------------------------------------------------
  localparam logic [3:0] PCICMD_MEM_WRITE     = 4'h7;
  localparam logic [3:0] PCICMD_MEM_WRITE_INV = 4'hf;

  // configuration access carried as one bundle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  offset;
    logic [1:0]  byte_en;
    logic [15:0] wdata;
  } pcicmd_cfg_t;

  // transaction kinds seen by the target decoder
  typedef enum logic [1:0] {
    PCICMD_TK_CFG = 2'b00,
    PCICMD_TK_MEM = 2'b01,
    PCICMD_TK_IO  = 2'b10,
    PCICMD_TK_ROM = 2'b11
  } pcicmd_kind_t;

endpackage : pcicmd_pkg

// ### testbench/pcicmd_monitor.sv
// assertions on the ports of the transaction control register block
// assumes one mclk domain; bound onto pcicmd_ctrl below
`timescale 1ns/100ps
module pcicmd_monitor
  import pcicmd_pkg::*;
(
  input wire logic         mclk,
  input wire logic         nrst,
  input wire pcicmd_cfg_t  cfg_req,
  input wire logic         cfg_ack,
  input wire logic [15:0]  cfg_rdata,
  input wire logic         tgt_valid,
  input wire pcicmd_kind_t tgt_kind,
  input wire logic         tgt_claim,
  input wire logic         mst_want,
  input wire logic         mst_req,
  input wire logic         addr_par_err,
  input wire logic         serr_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // a register hit, and a full write read straight back
  wire hit = cfg_req.valid && cfg_req.offset == 8'h04;
  sequence s_wr_rd;
    hit && cfg_req.write && cfg_req.byte_en == 2'b11 ##1 hit && !cfg_req.write;
  endsequence
  a_ack_hit: assert property (hit |=> cfg_ack)
    else $error("missing ack");
  a_ack_miss: assert property (!hit |=> !cfg_ack)
    else $error("stray ack");
  a_rd_idle: assert property (!hit || cfg_req.write |=> !cfg_rdata)
    else $error("read data outside a read");
  a_rsvd_zero: assert property ((cfg_rdata & 16'hfea8) == 0)
    else $error("fixed bit reads one");
  a_wr_back: assert property (s_wr_rd |=>
    cfg_rdata == ($past(cfg_req.wdata, 2) & 16'h0157))
    else $error("bad read back");
  a_cfg_claim: assert property (
    tgt_valid && tgt_kind == PCICMD_TK_CFG |=> tgt_claim)
    else $error("config access not claimed");
  a_serr_src: assert property (serr_out |-> $past(addr_par_err))
    else $error("serr without address parity error");
  a_req_want: assert property (mst_req |-> $past(mst_want))
    else $error("bus request without demand");
endmodule // pcicmd_monitor

bind pcicmd_ctrl pcicmd_monitor u_mon (
  .mclk         (mclk),
  .nrst         (nrst),
  .cfg_req      (cfg_req),
  .cfg_ack      (cfg_ack),
  .cfg_rdata    (cfg_rdata),
  .tgt_valid    (tgt_valid),
  .tgt_kind     (tgt_kind),
  .tgt_claim    (tgt_claim),
  .mst_want     (mst_want),
  .mst_req      (mst_req),
  .addr_par_err (addr_par_err),
  .serr_out     (serr_out)
);

// ### testbench/pcicmd_host.sv
// host model issuing config cycles to the register block
// assumes the caller is already on a falling mclk edge
`timescale 1ns/100ps
module pcicmd_host
  import pcicmd_pkg::*;
(
  output pcicmd_cfg_t cfg_req
);
  // idle until the first request
  initial cfg_req = '0;
  // one call per cycle; the request holds until replaced
  task automatic cfg_cycle(input pcicmd_cfg_t r);
    cfg_req <= r;
  endtask
endmodule // pcicmd_host

// ### testbench/tb.sv
// self-checking bench for the transaction control register block
// assumes pcicmd_host issues config cycles; side inputs come from s
`timescale 1ns/100ps
module tb
  import pcicmd_pkg::*;
;
  typedef struct packed {logic a; logic [15:0] d; logic [8:0] o;} pcicmd_exp_t;
  logic        mclk, nrst, a;
  logic [8:0]  o;
  logic [13:0] s;
  logic [15:0] d, m;
  pcicmd_cfg_t cfg_req, r;
  pcicmd_exp_t q[$], e, g;
  int          miscompares = 0, n_checks = 0;
  pcicmd_ctrl u_dut (.mclk(mclk), .nrst(nrst), .cfg_req(cfg_req),
    .cfg_ack(a), .cfg_rdata(d), .tgt_valid(s[13]),
    .tgt_kind(pcicmd_kind_t'(s[8:7])), .tgt_claim(o[8]), .mst_want(s[12]),
    .mst_mwi_ok(s[11]), .mst_req(o[7]), .mst_wr_cmd(o[6:3]),
    .addr_par_err(s[10]), .data_par_err(s[9]), .data_is_mst_read(s[6]),
    .data_is_tgt_write(s[5]), .data_is_special(s[4]), .serr_out(o[2]),
    .detected_parity_error_flag(s[3]), .reported_data_parity_flag(s[2]),
    .other_irq(s[1]), .irq_enable(s[0]), .perr_out(o[1]),
    .interrupt_request_line(o[0]));
  pcicmd_host u_host (.cfg_req(cfg_req));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one cycle of random stimulus; expectations use the old register value
  task automatic step(input bit quiet, input bit rd = 1'b0);
    logic [15:0] ln;
    @(negedge mclk);
    r = quiet ? '0 : pcicmd_cfg_t'(28'($urandom));
    s = quiet ? '0 : 14'($urandom);
    if (!quiet && $urandom_range(0, 3) != 0) r.offset = 8'h04;
    // a plain full read, used right after reset
    if (rd) r = {1'b1, 1'b0, PCICMD_OFS_CTRL, 2'b11, 16'h0000};
    e.a = r.valid && r.offset == 8'h04;
    e.d = (e.a && !r.write) ? m : 16'h0;
    // kind 0 config, 2 io, 1 and 3 memory or rom
    e.o = {s[13] && (s[8:7] == 2'd0 || (s[8:7] == 2'd2 ? m[0] : m[1])),
      s[12] & m[2], (m[4] & s[11]) ? 4'hf : 4'h7, m[8] & m[6] & s[10],
      m[6] & s[9] & !s[4] & (s[6] | s[5]),
      s[0] & (s[1] | m[6] & (s[3] | s[2]))};
    q.push_back(e);
    ln = {{8{r.byte_en[1]}}, {8{r.byte_en[0]}}} & 16'h0157;
    if (e.a && r.write) m = (m & ~ln) | (r.wdata & ln);
    u_host.cfg_cycle(r);
  endtask
  // results settle just after the taking edge
  always @(posedge mclk)
  begin
    #1;
    if (nrst && q.size() > 0)
    begin
      g = q.pop_front();
      chk({15'h0, a}, {15'h0, g.a});
      chk(d, g.d);
      chk({7'h0, o}, {7'h0, g.o});
    end
  end
  // the second pass proves a mid-run reset clears every register bit except mst_wr_cmd, which reloads the plain write code
  initial
  begin
    s = '0;
    void'($urandom(32'ha6f8cd70));
    repeat (2)
    begin
      nrst = 1'b0;
      m = '0;
      repeat (4) @(negedge mclk);
      // outputs while reset is still held
      chk({15'h0, a}, 16'h0000);
      chk(d, 16'h0000);
      chk({7'h0, o}, 16'h0038);
      nrst = 1'b1;
      step(1'b0, 1'b1);
      repeat (1500) step(1'b0);
      repeat (2) step(1'b1);
      @(negedge mclk);
      chk(16'(q.size()), 16'h0);
    end
    summarize();
  end
endmodule // tb
